// [dpm_port_ctrl.sv]
`timescale 1ns/1ps
module dpm_port_ctrl
  import dpm_pkg::*;
#(
  parameter int unsigned DATA_W = 18,
  parameter bit IS_LEFT = 1'b1,
  parameter bit FAST_GRADE = 1'b0
)
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic CE_N,
  output logic RW_N,
  output logic OE_N,
  output logic SEM_N,
  output logic UB_N,
  output logic LB_N,
  output logic [DEV_ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DQ_I,
  output logic [DATA_W-1:0] DQ_O,
  output logic DQ_OE_N,
  input wire logic COLLISION_N,
  input wire logic MAILBOX_FLAG_N
);
  // grade dependent counts
  localparam int unsigned WP_CYC = FAST_GRADE ? WRITE_PULSE_CYC_FAST : WRITE_PULSE_CYC_SLOW;
  localparam int unsigned CA_CYC = FAST_GRADE ? COLL_ASSERT_CYC_FAST : COLL_ASSERT_CYC_SLOW;
  localparam int unsigned STROBE_CYC = ((WP_CYC > CA_CYC) ? WP_CYC : CA_CYC) + SYNC_STAGES;
  localparam int unsigned HOLD_CYC = FAST_GRADE ? WRITE_HOLD_CYC_FAST : WRITE_HOLD_CYC_SLOW;
  localparam int unsigned ACC_CYC =
    (FAST_GRADE ? ACCESS_CYC_FAST : ACCESS_CYC_SLOW) + SYNC_STAGES;
  localparam logic [3:0] ARB_N = 4'(ARB_SETUP_CYC - 1);
  localparam logic [3:0] STROBE_N = 4'(STROBE_CYC - 1);
  localparam logic [3:0] HOLD_N = 4'(HOLD_CYC - 1);
  localparam logic [3:0] ACC_N = 4'(ACC_CYC - 1);
  localparam logic [3:0] GAP_N = 4'(SEM_GAP_CYC - 1);
  localparam logic [12:0] OWN_MBOX = IS_LEFT ? MBOX_TO_LEFT_ADDR : MBOX_TO_RIGHT_ADDR;

  if (DATA_W < 1 || DATA_W > 31)
  begin : g_bad_width
    $error("DATA_W must lie between 1 and 31");
  end
  if (STROBE_CYC > 16 || ACC_CYC > 16 || HOLD_CYC > 16)
  begin : g_bad_count
    $error("cycle counts exceed the 4-bit counter");
  end

  // pins and writes that drive the device
  function automatic logic is_write(input dpm_op_t op, input logic readback);
    return (op == OP_RAM_WR || op == OP_SEM_WR) && !readback;
  endfunction : is_write

  function automatic logic reg_known(input logic [APB_AW-1:0] a);
    return a == REG_CTRL || a == REG_ADDR || a == REG_WDATA || a == REG_RDATA ||
           a == REG_STATUS;
  endfunction : reg_known

  logic [DATA_W+1:0] pins_sync;
  logic coll_n_s;
  logic flag_n_s;
  logic [DATA_W-1:0] dq_s;

  dpm_sync #(
    .W(DATA_W + 2),
    .RST_VAL(1'b1)
  ) u_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .async_i({COLLISION_N, MAILBOX_FLAG_N, DQ_I}),
    .sync_o(pins_sync)
  );
  assign coll_n_s = pins_sync[DATA_W+1];
  assign flag_n_s = pins_sync[DATA_W];
  assign dq_s = pins_sync[DATA_W-1:0];

  // register file state
  dpm_op_t op_q, op_d;
  logic [1:0] lane_q, lane_d;
  logic [12:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic go;

  // sequencer state
  dpm_state_t state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  dpm_op_t cur_op_q, cur_op_d;
  logic [12:0] cur_addr_q, cur_addr_d;
  logic [DATA_W-1:0] cur_data_q, cur_data_d;
  logic [1:0] cur_lane_q, cur_lane_d;
  logic readback_q, readback_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic coll_seen_q, coll_seen_d;
  logic sem_own_q, sem_own_d;
  logic init_done_q, init_done_d;

  // pin registers
  logic ce_n_q, ce_n_d, rw_n_q, rw_n_d, oe_n_q, oe_n_d, sem_n_q, sem_n_d;
  logic ub_n_q, ub_n_d, lb_n_q, lb_n_d, dq_oe_n_q, dq_oe_n_d;
  logic [12:0] pin_addr_q, pin_addr_d;
  logic [DATA_W-1:0] dq_o_q, dq_o_d;
  logic [31:0] status;
  logic pin_active;
  logic pin_sem;
  logic pin_wr;

  always_comb
  begin
    status = 32'h0;
    status[ST_BUSY_BIT] = state_q != S_IDLE;
    status[ST_DONE_BIT] = done_q;
    status[ST_COLL_SEEN_BIT] = coll_seen_q;
    status[ST_MBOX_BIT] = !flag_n_s;
    status[ST_SEM_OWN_BIT] = sem_own_q;
    status[ST_INIT_BIT] = init_done_q;
    status[ST_COLL_NOW_BIT] = !coll_n_s;
  end

  // apb slave: read data latched in setup, writes in access
  always_comb
  begin
    op_d = op_q;
    lane_d = lane_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    go = 1'b0;
    if (PSEL && !PENABLE)
    begin
      pslverr_d = !reg_known(PADDR);
      case (PADDR)
        REG_CTRL: prdata_d = {27'h0, lane_q, op_q, 1'b0};
        REG_ADDR: prdata_d = {19'h0, addr_q};
        REG_WDATA: prdata_d = 32'(wdata_q);
        REG_RDATA: prdata_d = 32'(rdata_q);
        REG_STATUS: prdata_d = status;
        default: prdata_d = 32'h0;
      endcase
    end
    if (PSEL && PENABLE && PWRITE)
    begin
      case (PADDR)
        REG_CTRL:
        begin
          op_d = dpm_op_t'(PWDATA[CTRL_OP_LSB +: 2]);
          lane_d = PWDATA[CTRL_LANE_LSB +: 2];
          go = PWDATA[CTRL_GO_BIT];
        end
        REG_ADDR: addr_d = PWDATA[12:0];
        REG_WDATA: wdata_d = PWDATA[DATA_W-1:0];
        default: go = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      op_q <= OP_RAM_RD;
      lane_q <= CTRL_LANE_RST;
      addr_q <= 13'h0;
      wdata_q <= '0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      op_q <= op_d;
      lane_q <= lane_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // sequencer: setup, access or strobe, stall, hold, gap
  always_comb
  begin
    state_d = state_q;
    cnt_d = (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
    cur_op_d = cur_op_q;
    cur_addr_d = cur_addr_q;
    cur_data_d = cur_data_q;
    cur_lane_d = cur_lane_q;
    readback_d = readback_q;
    rdata_d = rdata_q;
    done_d = done_q;
    coll_seen_d = coll_seen_q;
    sem_own_d = sem_own_q;
    init_done_d = init_done_q;
    case (state_q)
      S_IDLE:
      begin
        if (!init_done_q)
        begin
          cur_op_d = OP_RAM_RD;
          cur_addr_d = OWN_MBOX;
          cur_lane_d = 2'h3;
          state_d = S_SETUP;
          cnt_d = ARB_N;
        end
        else if (go)
        begin
          cur_op_d = op_d;
          cur_addr_d = addr_d;
          cur_data_d = wdata_d;
          cur_lane_d = lane_d;
          done_d = 1'b0;
          coll_seen_d = 1'b0;
          state_d = S_SETUP;
          cnt_d = ARB_N;
        end
      end
      S_SETUP:
      begin
        // address and enable settle before any strobe
        if (cnt_q == 4'h0)
        begin
          state_d = is_write(cur_op_q, readback_q) ? S_STROBE : S_ACCESS;
          cnt_d = is_write(cur_op_q, readback_q) ? STROBE_N : ACC_N;
        end
      end
      S_ACCESS:
      begin
        if (cnt_q == 4'h0)
        begin
          rdata_d = dq_s;
          if (cur_op_q == OP_SEM_WR || cur_op_q == OP_SEM_RD)
            sem_own_d = !dq_s[0];
          state_d = S_GAP;
          cnt_d = GAP_N;
        end
      end
      S_STROBE:
      begin
        // strobe spans the collision assert time plus sync
        if (cur_op_q == OP_RAM_WR && !coll_n_s)
          coll_seen_d = 1'b1;
        if (cnt_q == 4'h0)
        begin
          if (cur_op_q == OP_RAM_WR && !coll_n_s)
            state_d = S_STALL;
          else
          begin
            state_d = S_GAP;
            cnt_d = GAP_N;
          end
        end
      end
      S_STALL:
      begin
        coll_seen_d = 1'b1;
        if (coll_n_s)
        begin
          state_d = S_HOLD;
          cnt_d = HOLD_N;
        end
      end
      S_HOLD:
      begin
        if (cnt_q == 4'h0)
        begin
          state_d = S_GAP;
          cnt_d = GAP_N;
        end
      end
      S_GAP:
      begin
        if (cnt_q == 4'h0)
        begin
          if (cur_op_q == OP_SEM_WR && !readback_q)
          begin
            readback_d = 1'b1;
            state_d = S_SETUP;
            cnt_d = ARB_N;
          end
          else
          begin
            readback_d = 1'b0;
            done_d = 1'b1;
            init_done_d = 1'b1;
            state_d = S_IDLE;
          end
        end
      end
      default:
      begin
        state_d = S_IDLE;
        cnt_d = 4'h0;
      end
    endcase
  end

  // pin levels follow the next state, so they change with state_q
  always_comb
  begin
    pin_active = state_d == S_SETUP || state_d == S_ACCESS || state_d == S_STROBE ||
                 state_d == S_STALL || state_d == S_HOLD;
    pin_sem = cur_op_d == OP_SEM_WR || cur_op_d == OP_SEM_RD;
    pin_wr = is_write(cur_op_d, readback_d);
    ce_n_d = !(pin_active && !pin_sem);
    sem_n_d = !(pin_active && pin_sem);
    oe_n_d = !(pin_active && !pin_wr);
    rw_n_d = !(state_d == S_STROBE || state_d == S_STALL || state_d == S_HOLD);
    ub_n_d = !(pin_active && !pin_sem && cur_lane_d[1]);
    lb_n_d = !(pin_active && !pin_sem && cur_lane_d[0]);
    dq_oe_n_d = !(pin_active && pin_wr);
    pin_addr_d = cur_addr_d;
    dq_o_d = pin_sem ? {{(DATA_W-1){1'b1}}, cur_data_d[0]} : cur_data_d;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      cur_op_q <= OP_RAM_RD;
      cur_addr_q <= 13'h0;
      cur_data_q <= '0;
      cur_lane_q <= CTRL_LANE_RST;
      readback_q <= 1'b0;
      rdata_q <= '0;
      done_q <= 1'b0;
      coll_seen_q <= 1'b0;
      sem_own_q <= 1'b0;
      init_done_q <= 1'b0;
      ce_n_q <= 1'b1;
      rw_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      sem_n_q <= 1'b1;
      ub_n_q <= 1'b1;
      lb_n_q <= 1'b1;
      dq_oe_n_q <= 1'b1;
      pin_addr_q <= 13'h0;
      dq_o_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cur_op_q <= cur_op_d;
      cur_addr_q <= cur_addr_d;
      cur_data_q <= cur_data_d;
      cur_lane_q <= cur_lane_d;
      readback_q <= readback_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
      coll_seen_q <= coll_seen_d;
      sem_own_q <= sem_own_d;
      init_done_q <= init_done_d;
      ce_n_q <= ce_n_d;
      rw_n_q <= rw_n_d;
      oe_n_q <= oe_n_d;
      sem_n_q <= sem_n_d;
      ub_n_q <= ub_n_d;
      lb_n_q <= lb_n_d;
      dq_oe_n_q <= dq_oe_n_d;
      pin_addr_q <= pin_addr_d;
      dq_o_q <= dq_o_d;
    end
  end

  // outputs
  assign PREADY = 1'b1; // zero wait states
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;
  assign CE_N = ce_n_q;
  assign RW_N = rw_n_q;
  assign OE_N = oe_n_q;
  assign SEM_N = sem_n_q;
  assign UB_N = ub_n_q;
  assign LB_N = lb_n_q;
  assign ADDR = pin_addr_q;
  assign DQ_O = dq_o_q;
  assign DQ_OE_N = dq_oe_n_q;
endmodule : dpm_port_ctrl

// [dpm_pkg.sv]
// Function
// - semaphore contention window gives no guaranteed winner
// - earlier stable port wins after 5 ns setup
// - slave collision input precedes write strobe
// - loser holds write 12/15 ns after collision rises
// - mailbox flags undefined at power-up; initialise them
package dpm_pkg;
  // clock and pin timing, pin times in ns, clock period in ps
  localparam int unsigned CLK_PERIOD_PS = 4000;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned ARB_SETUP_NS = 5;
  localparam int unsigned SEM_WINDOW_NS = 5;
  localparam int unsigned SEM_WR_TO_RD_NS = 5;
  localparam int unsigned WRITE_PULSE_NS_FAST = 12;
  localparam int unsigned WRITE_PULSE_NS_SLOW = 15;
  localparam int unsigned WRITE_HOLD_NS_FAST = 12;
  localparam int unsigned WRITE_HOLD_NS_SLOW = 15;
  localparam int unsigned COLL_ASSERT_NS_FAST = 15;
  localparam int unsigned COLL_ASSERT_NS_SLOW = 20;
  localparam int unsigned ACCESS_NS_FAST = 15;
  localparam int unsigned ACCESS_NS_SLOW = 20;

  // least time to whole cycles, never below one
  function automatic int unsigned min_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c == 0) ? 1 : c;
  endfunction : min_cycles

  localparam int unsigned ARB_SETUP_CYC = min_cycles(ARB_SETUP_NS);
  localparam int unsigned SEM_GAP_CYC = min_cycles((SEM_WINDOW_NS > SEM_WR_TO_RD_NS) ?
                                                   SEM_WINDOW_NS : SEM_WR_TO_RD_NS);
  localparam int unsigned WRITE_PULSE_CYC_FAST = min_cycles(WRITE_PULSE_NS_FAST);
  localparam int unsigned WRITE_PULSE_CYC_SLOW = min_cycles(WRITE_PULSE_NS_SLOW);
  localparam int unsigned WRITE_HOLD_CYC_FAST = min_cycles(WRITE_HOLD_NS_FAST);
  localparam int unsigned WRITE_HOLD_CYC_SLOW = min_cycles(WRITE_HOLD_NS_SLOW);
  localparam int unsigned COLL_ASSERT_CYC_FAST = min_cycles(COLL_ASSERT_NS_FAST);
  localparam int unsigned COLL_ASSERT_CYC_SLOW = min_cycles(COLL_ASSERT_NS_SLOW);
  localparam int unsigned ACCESS_CYC_FAST = min_cycles(ACCESS_NS_FAST);
  localparam int unsigned ACCESS_CYC_SLOW = min_cycles(ACCESS_NS_SLOW);

  // device address space
  localparam int unsigned DEV_ADDR_W = 13;
  localparam logic [12:0] MBOX_TO_LEFT_ADDR = 13'h1ffe;
  localparam logic [12:0] MBOX_TO_RIGHT_ADDR = 13'h1fff;

  // own register map, byte offsets
  localparam int unsigned APB_AW = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_WDATA = 12'h008;
  localparam logic [11:0] REG_RDATA = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;

  // field positions and reset values
  localparam int unsigned CTRL_GO_BIT = 0;
  localparam int unsigned CTRL_OP_LSB = 1;
  localparam int unsigned CTRL_LANE_LSB = 3;
  localparam logic [1:0] CTRL_OP_RST = 2'h0;
  localparam logic [1:0] CTRL_LANE_RST = 2'h3;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_DONE_BIT = 1;
  localparam int unsigned ST_COLL_SEEN_BIT = 2;
  localparam int unsigned ST_MBOX_BIT = 3;
  localparam int unsigned ST_SEM_OWN_BIT = 4;
  localparam int unsigned ST_INIT_BIT = 5;
  localparam int unsigned ST_COLL_NOW_BIT = 6;

  typedef enum logic [1:0] {
    OP_RAM_RD = 2'h0,
    OP_RAM_WR = 2'h1,
    OP_SEM_WR = 2'h2,
    OP_SEM_RD = 2'h3
  } dpm_op_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_SETUP = 7'h02,
    S_ACCESS = 7'h04,
    S_STROBE = 7'h08,
    S_STALL = 7'h10,
    S_HOLD = 7'h20,
    S_GAP = 7'h40
  } dpm_state_t;
endpackage : dpm_pkg

// [dpm_sync.sv]
`timescale 1ns/1ps
module dpm_sync
  import dpm_pkg::*;
#(
  parameter int unsigned W = 1,
  parameter logic RST_VAL = 1'b1
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // two stages; only the second stage reads the first
  always_comb
  begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_q <= {W{RST_VAL}};
      sync_q <= {W{RST_VAL}};
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : dpm_sync

// [dpm_port_ctrl_sva.sv]
`timescale 1ns/1ps
module dpm_chk
  import dpm_pkg::*;
#(
  parameter int unsigned DATA_W = 18,
  parameter bit IS_LEFT = 1'b1,
  parameter bit FAST_GRADE = 1'b0
)
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic PSLVERR,
  input wire logic CE_N,
  input wire logic RW_N,
  input wire logic OE_N,
  input wire logic SEM_N,
  input wire logic UB_N,
  input wire logic LB_N,
  input wire logic [DEV_ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DQ_O,
  input wire logic DQ_OE_N,
  input wire logic COLLISION_N
);
  localparam logic [12:0] OWN_MBOX = IS_LEFT ? MBOX_TO_LEFT_ADDR : MBOX_TO_RIGHT_ADDR;
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  // strobe begun with collision held low for the whole strobe
  sequence s_coll_strobe;
    ($fell(RW_N) && !COLLISION_N) ##1 !COLLISION_N [*7];
  endsequence
  sequence s_two_strobe;
    !RW_N ##1 !RW_N;
  endsequence
  property p_stall;
    s_coll_strobe |=> !RW_N [*2];
  endproperty
  a_stall: assert property (p_stall) else $error("strobe not stalled");
  property p_hold;
    $rose(COLLISION_N) && !RW_N |-> !RW_N [*4];
  endproperty
  a_hold: assert property (p_hold) else $error("write hold too short");
  property p_init;
    $rose(RST_N) |-> ##[0:2] (!CE_N && !OE_N && ADDR == OWN_MBOX);
  endproperty
  a_init: assert property (p_init) else $error("no mailbox init read");
  property p_excl;
    CE_N || SEM_N;
  endproperty
  a_excl: assert property (p_excl) else $error("ram and semaphore both on");
  property p_sem_wr;
    !SEM_N && !RW_N |-> CE_N && UB_N && LB_N;
  endproperty
  a_sem_wr: assert property (p_sem_wr) else $error("semaphore write lanes on");
  property p_sem_gap;
    $rose(SEM_N) |-> SEM_N [*2];
  endproperty
  a_sem_gap: assert property (p_sem_gap) else $error("semaphore gap short");
  property p_drive;
    !RW_N |-> !DQ_OE_N && OE_N;
  endproperty
  a_drive: assert property (p_drive) else $error("data not driven in write");
  property p_wr_stable;
    s_two_strobe |-> $stable(ADDR) && $stable(DQ_O);
  endproperty
  a_wr_stable: assert property (p_wr_stable) else $error("write moved");
  property p_addr_move;
    $changed(ADDR) |-> RW_N && $past(RW_N);
  endproperty
  a_addr_move: assert property (p_addr_move) else $error("address moved in write");
  property p_slverr;
    PSEL && PENABLE && PADDR > REG_STATUS |-> PSLVERR;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped without error");
endmodule : dpm_chk

bind dpm_port_ctrl dpm_chk #(.DATA_W(DATA_W), .IS_LEFT(IS_LEFT), .FAST_GRADE(FAST_GRADE)) u_chk (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PSLVERR(PSLVERR), .CE_N(CE_N), .RW_N(RW_N), .OE_N(OE_N), .SEM_N(SEM_N),
  .UB_N(UB_N), .LB_N(LB_N), .ADDR(ADDR), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N),
  .COLLISION_N(COLLISION_N));

// [dpm_dev_model.sv]
`timescale 1ns/1ps
module dpm_dev_model
  import dpm_pkg::*;
#(
  parameter int unsigned DATA_W = 18,
  parameter realtime HOLD_NS = 15.0
)
(
  input wire logic ce_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic sem_n,
  input wire logic ub_n,
  input wire logic lb_n,
  input wire logic [DEV_ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic dq_oe_n,
  input wire logic far_busy,
  input wire logic far_mail,
  output logic [DATA_W-1:0] dq_i,
  output logic collision_n,
  output logic mailbox_flag_n
);
  logic [DATA_W-1:0] mem [0:8191];
  logic [7:0] sem_q = 8'hff;
  logic flag_q = 1'bx;
  logic [DATA_W-1:0] last_q = '0;
  logic [DATA_W-1:0] wd;
  logic [DEV_ADDR_W-1:0] wa;
  logic wub;
  logic wlb;
  realtime rise_t = -1.0e6;
  wire wr_act = !ce_n && !rw_n && sem_n;
  wire sw_act = !sem_n && !rw_n && ce_n;
  wire rd_on = !oe_n && (!ce_n || !sem_n);
  wire [DATA_W-1:0] drv = !ce_n ? mem[addr] : {DATA_W{sem_q[addr[2:0]]}};
  // far port wins every contention while this port is enabled
  // collision follows enable, so it leads the write strobe
  assign collision_n = !(far_busy && !ce_n);
  assign mailbox_flag_n = flag_q;
  // wire level, released bus shows inverted last value
  assign dq_i = !dq_oe_n ? dq_o : rd_on ? drv : ~last_q;
  always @(drv or rd_on) if (rd_on) last_q = drv;
  // latch what the strobe carries
  always @*
  begin
    if (wr_act || sw_act)
    begin
      wa = addr;
      wd = dq_o;
      wub = ub_n;
      wlb = lb_n;
    end
  end
  always @(negedge far_busy) rise_t = $realtime;
  // commit at strobe end, dropped under collision or short hold
  always @(negedge wr_act)
  begin
    if (!far_busy && $realtime - rise_t >= HOLD_NS)
    begin
      if (!wub) mem[wa][DATA_W-1:9] = wd[DATA_W-1:9];
      if (!wlb) mem[wa][8:0] = wd[8:0];
    end
  end
  always @(negedge sw_act) sem_q[wa[2:0]] = wd[0];
  // mailbox flag set by far port, cleared by own read access
  always @(posedge far_mail) flag_q = 1'b0;
  always @* if (!ce_n && !oe_n && addr == MBOX_TO_LEFT_ADDR) flag_q = 1'b1;
endmodule : dpm_dev_model

// [test_dpm_port_ctrl.sv]
`timescale 1ns/1ps
module test_dpm_port_ctrl
  import dpm_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic far_busy = 1'b0;
  logic far_mail = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, st, q;
  logic pready, pslverr, err, ce_n, rw_n, oe_n, sem_n, ub_n, lb_n, dq_oe_n, coll_n, mbox_n;
  logic [12:0] dev_addr;
  logic [17:0] dq_i, dq_o;
  logic [12:0] adrs [2] = '{13'h0123, 13'h1ffe};
  logic [17:0] pats [2] = '{18'h2a5c3, 18'h15a3c};
  int checked = 0;
  int n_mismatch = 0;
  int cyc = 0;
  always #2 core_clk = ~core_clk;
  dpm_port_ctrl #(.DATA_W(18), .IS_LEFT(1'b1), .FAST_GRADE(1'b0)) dut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .CE_N(ce_n), .RW_N(rw_n), .OE_N(oe_n), .SEM_N(sem_n), .UB_N(ub_n), .LB_N(lb_n),
    .ADDR(dev_addr), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE_N(dq_oe_n), .COLLISION_N(coll_n),
    .MAILBOX_FLAG_N(mbox_n));
  dpm_dev_model #(.DATA_W(18), .HOLD_NS(15.0)) u_dev (
    .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .sem_n(sem_n), .ub_n(ub_n), .lb_n(lb_n),
    .addr(dev_addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .far_busy(far_busy),
    .far_mail(far_mail), .dq_i(dq_i), .collision_n(coll_n), .mailbox_flag_n(mbox_n));
  // one apb transfer, setup then access until ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // poll status until a bit sets, bounded
  task automatic poll(input int b);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, REG_STATUS, '0, st);
      n++;
    end
    while (st[b] !== 1'b1 && n < 100);
  endtask : poll
  task automatic op(input logic [1:0] o, input logic [12:0] a, input logic [17:0] d);
    apb(1'b1, REG_ADDR, {19'h0, a}, q);
    apb(1'b1, REG_WDATA, {14'h0, d}, q);
    apb(1'b1, REG_CTRL, {27'h0, 2'h3, o, 1'b1}, q);
  endtask : op
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    poll(ST_INIT_BIT);
    chk("init_status", st & 32'h2c, 32'h20);
    for (int i = 0; i < 2; i++)
    begin
      op(OP_RAM_WR, adrs[i], pats[i]);
      poll(ST_DONE_BIT);
      op(OP_RAM_RD, adrs[i], '0);
      poll(ST_DONE_BIT);
      apb(1'b0, REG_RDATA, '0, q);
      chk("ram_rdata", q, {14'h0, pats[i]});
    end
    far_mail <= 1'b1;
    @(posedge core_clk);
    far_mail <= 1'b0;
    poll(ST_MBOX_BIT);
    chk("mbox_set", st & 32'h8, 32'h8);
    op(OP_RAM_RD, MBOX_TO_LEFT_ADDR, '0);
    poll(ST_DONE_BIT);
    chk("mbox_clr", st & 32'h8, 32'h0);
    apb(1'b0, REG_RDATA, '0, q);
    chk("mbox_word", q, {14'h0, pats[1]});
    far_busy <= 1'b1;
    op(OP_RAM_WR, adrs[0], 18'h3c0f1);
    repeat (30) @(posedge core_clk);
    apb(1'b0, REG_STATUS, '0, st);
    chk("stalled", st & 32'h43, 32'h41);
    far_busy <= 1'b0;
    poll(ST_DONE_BIT);
    chk("coll_seen", st & 32'h47, 32'h06);
    op(OP_RAM_RD, adrs[0], '0);
    poll(ST_DONE_BIT);
    apb(1'b0, REG_RDATA, '0, q);
    chk("held_write", q, 32'h3c0f1);
    for (int v = 0; v < 2; v++)
    begin
      op(OP_SEM_WR, 13'h0003, {17'h0, v[0]});
      poll(ST_DONE_BIT);
      chk("sem_own", st & 32'h10, v ? 32'h0 : 32'h10);
      apb(1'b0, REG_RDATA, '0, q);
      chk("sem_data", q, v ? 32'h3ffff : 32'h0);
      op(OP_SEM_RD, 13'h0003, '0);
      poll(ST_DONE_BIT);
      chk("sem_read", st & 32'h10, v ? 32'h0 : 32'h10);
    end
    apb(1'b0, 12'h020, '0, q);
    chk("unmapped", {q[30:0], err}, 32'h1);
    give_verdict();
  end
endmodule : test_dpm_port_ctrl
